/* rtl/supply_defines.svh */
// offsets, field positions, reset values and timing counts of the block
// What this block does
// [R1] reset pin is held low for one millisecond whenever a reset is issued
// [R2] reset driven by the host and then released enters normal-request
// [R3] interrupt pin goes low on an enabled event, stays low until cleared
// [R4] wake-up events are reported on the interrupt pin
// [R5] three level inputs are readable over the serial port, act as wake-ups
// [R6] main regulator stays on in normal-request, normal and standby modes
// [R7] main undervoltage gives a one millisecond reset and a cause flag
// [R8] main thermal pre-warning sets a thermal flag, maskable interrupt
// [R9] main thermal shut-off sets a flag, interrupts, turns main off
// [R10] main regulator returns on once temperature falls below pre-warning
// [R11] main regulator is off in sleep, emergency and without battery
// [R12] peripheral regulator is on only in normal mode
// [R13] peripheral undervoltage sets a supply status flag
// [R14] peripheral thermal pre-warning sets a flag, maskable interrupt
// [R15] peripheral shut-off latches off until a serial restart command
// [R16] peripheral regulator is off whenever the main regulator is off
// [R17] battery switch follows per-mode configuration, sleep only in sense
// [R18] battery switch off in normal-request, main off outside sleep, peripheral shutdown
// [R19] switch overtemperature sets a flag, opens until temperature recovers
// [R20] battery undervoltage sets the battery-low flag, maskable interrupt
// [R21] battery overvoltage sets a flag, interrupts, takes no other action
// [R22] serial transfers are taken only while chip select is low
// [R23] interrupt pin low while any enabled pending source is uncleared
`ifndef SUPPLY_DEFINES_SVH
`define SUPPLY_DEFINES_SVH

// ==========================================================
// timing
`define CLK_PERIOD_NS   8
`define RST_PULSE_NS    1000000
`define RST_PULSE_CYC   (`RST_PULSE_NS / `CLK_PERIOD_NS)
`define RST_HOLDOFF     2'h3

// ==========================================================
// register offsets
`define A_MODE          3'h0
`define A_IRQ_EN        3'h1
`define A_SW_CFG        3'h2
`define A_CAUSE         3'h3
`define A_THERM         3'h4
`define A_SUPPLY        3'h5
`define A_WAKE          3'h6
`define A_LEVEL         3'h7

// ==========================================================
// field positions
`define MODE_RESTART    2
`define CAUSE_UV        0
`define CAUSE_EXT       1
`define IE_THERM        0
`define IE_BAT          1
`define IE_WAKE         2
`define IE_SUPPLY       3
`define CFG_NORMAL      0
`define CFG_STANDBY     1
`define CFG_SLEEP       2

// ==========================================================
// reset values
`define IRQ_EN_RST      4'h0
`define SW_CFG_RST      4'h0
`define CAUSE_RST       4'h1

`endif

/* rtl/supply_pkg.sv */
// types shared by the supply mode monitor and control block
package supply_pkg;

    typedef enum logic [2:0] {
        M_NREQ,
        M_NORMAL,
        M_STANDBY,
        M_SLEEP,
        M_EMERG
    } mode_t;

    // analog comparator levels, all active high
    typedef struct packed {
        logic       main_uv;
        logic       main_pw;
        logic       main_sd;
        logic       per_uv;
        logic       per_pw;
        logic       per_sd;
        logic       sw_ot;
        logic       bat_low;
        logic       bat_high;
        logic       bat_ok;
        logic       cyc_on;
        logic [2:0] level;
    } analog_t;

    typedef struct packed {
        logic       wr;
        logic [2:0] addr;
        logic [3:0] data;
    } spi_cmd_t;

endpackage : supply_pkg

/* rtl/supply_mode_monitor_control.sv */
// supply mode, monitor and control logic with its serial port
`timescale 1ns/100ps
`include "supply_defines.svh"

module supply_mode_monitor_control
    import supply_pkg::*;
#(
    parameter int RST_PULSE_CYCLES = `RST_PULSE_CYC
) (
    // core clock and reset
    input  wire logic    core_clk,
    input  wire logic    reset_n,
    // analog monitors and host reset pin input
    input  wire analog_t sense,
    input  wire logic    rst_in,
    // serial port
    input  wire logic    sclk,
    input  wire logic    cs_n,
    input  wire logic    mosi,
    output logic         miso,
    // reset and interrupt pins
    output logic         rst_out,
    output logic         rst_oe_n,
    output logic         int_n,
    // supply enables and mode
    output logic         main_en,
    output logic         periph_en,
    output logic         switch_en,
    output mode_t        mode
);

    localparam int RW = $clog2(RST_PULSE_CYCLES + 1);

    // ==========================================================
    // serial port, link clock domain
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [7:0] rx_word_q;
    logic       rx_tgl_q;
    logic       miso_q;
    logic [6:0] reply_q;
    logic [2:0] tx_idx;

    // chip select high ends the frame without needing an sclk edge
    always_ff @(posedge sclk or posedge cs_n or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_q <= 3'h0;
            shift_q   <= 7'h00;
        end else if (cs_n) begin
            bit_cnt_q <= 3'h0; // [R22]
            shift_q   <= 7'h00;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1; // [R22]
            shift_q   <= {shift_q[5:0], mosi};
        end
    end

    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_word_q <= 8'h00;
            rx_tgl_q  <= 1'b0;
        end else if (!cs_n && bit_cnt_q == 3'h7) begin
            rx_word_q <= {shift_q, mosi}; // [R22]
            rx_tgl_q  <= ~rx_tgl_q;
        end
    end

    // first bit out is a zero, reply follows msb first
    assign tx_idx = 3'h7 - bit_cnt_q;

    always_ff @(negedge sclk or posedge cs_n or negedge reset_n) begin
        if (!reset_n) begin
            miso_q <= 1'b0;
        end else if (cs_n) begin
            miso_q <= 1'b0;
        end else if (bit_cnt_q != 3'h0) begin
            miso_q <= reply_q[tx_idx];
        end
    end

    assign miso = miso_q;

    // ==========================================================
    // crossings into the core domain
    analog_t an_s1_q;
    analog_t an_q;
    logic    rst_s1_q;
    logic    rst_s2_q;
    logic    tg_s1_q;
    logic    tg_s2_q;
    logic    tg_s3_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            an_s1_q  <= '0;
            an_q     <= '0;
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            an_s1_q  <= sense;
            an_q     <= an_s1_q;
            rst_s1_q <= rst_in;
            rst_s2_q <= rst_s1_q;
        end
    end

    // rx_word_q stays put for a whole frame after the toggle moves
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tg_s1_q <= 1'b0;
            tg_s2_q <= 1'b0;
            tg_s3_q <= 1'b0;
        end else begin
            tg_s1_q <= rx_tgl_q;
            tg_s2_q <= tg_s1_q;
            tg_s3_q <= tg_s2_q;
        end
    end

    spi_cmd_t cmd;
    logic     rx_evt;
    logic     wr_evt;

    assign cmd    = rx_word_q;
    assign rx_evt = tg_s2_q ^ tg_s3_q;
    assign wr_evt = rx_evt && cmd.wr;

    // ==========================================================
    // wake detection on the level inputs
    logic [2:0] lvl_prev_q;
    logic       low_power;
    logic [2:0] wake_evt;
    logic       sleep_wake;

    assign low_power  = (mode == M_STANDBY) || (mode == M_SLEEP);
    assign wake_evt   = (an_q.level ^ lvl_prev_q) & {3{low_power}}; // [R5]
    assign sleep_wake = (mode == M_SLEEP) && (|wake_evt);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lvl_prev_q <= 3'h0;
        end else begin
            lvl_prev_q <= an_q.level;
        end
    end

    // ==========================================================
    // reset pulse and host reset detection
    logic [RW-1:0] rst_cnt_q;
    logic [RW-1:0] rst_cnt_d;
    logic          rst_start;
    logic [1:0]    hold_q;
    logic          ext_low_q;
    logic          ext_rel;
    logic          drive_end;

    assign rst_start = an_q.main_uv || sleep_wake; // [R7]
    assign drive_end = !rst_oe_n && (rst_cnt_d == '0);
    assign ext_rel   = ext_low_q && rst_s2_q; // [R2]

    always_comb begin
        rst_cnt_d = rst_cnt_q;
        if (rst_start) begin
            rst_cnt_d = RW'(RST_PULSE_CYCLES); // [R1] [R7]
        end else if (rst_cnt_q != '0) begin
            rst_cnt_d = rst_cnt_q - RW'(1);
        end
    end

    // power-up starts with a full pulse already loaded
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_cnt_q <= RW'(RST_PULSE_CYCLES);
            rst_oe_n  <= 1'b0;
            rst_out   <= 1'b0;
        end else begin
            rst_cnt_q <= rst_cnt_d;
            rst_oe_n  <= (rst_cnt_d == '0); // [R1]
            rst_out   <= 1'b0;
        end
    end

    // the synchronised pin still reads low just after we let go
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_q    <= `RST_HOLDOFF;
            ext_low_q <= 1'b0;
        end else begin
            if (!rst_oe_n) begin
                hold_q <= `RST_HOLDOFF;
            end else if (hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end
            if (!rst_oe_n || hold_q != 2'h0) begin
                ext_low_q <= 1'b0;
            end else if (!rst_s2_q) begin
                ext_low_q <= 1'b1;
            end else begin
                ext_low_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // operating mode
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode <= M_NREQ;
        end else if (rst_start || drive_end || ext_rel) begin
            mode <= M_NREQ; // [R2]
        end else if (wr_evt && cmd.addr == `A_MODE) begin
            case (cmd.data[1:0])
                2'h0:    mode <= M_NORMAL;
                2'h1:    mode <= M_STANDBY;
                2'h2:    mode <= M_SLEEP;
                default: mode <= M_EMERG;
            endcase
        end
    end

    // ==========================================================
    // configuration written by the host
    logic [3:0] irq_en_q;
    logic [3:0] sw_cfg_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_en_q <= `IRQ_EN_RST;
            sw_cfg_q <= `SW_CFG_RST;
        end else if (wr_evt) begin
            if (cmd.addr == `A_IRQ_EN) begin
                irq_en_q <= cmd.data; // [R3]
            end
            if (cmd.addr == `A_SW_CFG) begin
                sw_cfg_q <= cmd.data; // [R17]
            end
        end
    end

    // ==========================================================
    // sticky flags, write one to clear, a live source wins
    logic [3:0] cause_q;
    logic [3:0] therm_q;
    logic [3:0] supply_q;
    logic [3:0] wake_q;

    function automatic logic [3:0] clr_of(input logic [2:0] a);
        clr_of = (wr_evt && cmd.addr == a) ? cmd.data : 4'h0;
    endfunction : clr_of

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cause_q <= `CAUSE_RST;
        end else begin
            cause_q <= (cause_q & ~clr_of(`A_CAUSE))
                     | {2'h0, ext_rel, an_q.main_uv}; // [R7]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            therm_q <= 4'h0;
        end else begin
            therm_q <= (therm_q & ~clr_of(`A_THERM))
                     | {an_q.per_sd, an_q.per_pw,
                        an_q.main_sd, an_q.main_pw}; // [R8] [R9] [R14] [R15]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            supply_q <= 4'h0;
        end else begin
            supply_q <= (supply_q & ~clr_of(`A_SUPPLY))
                      | {an_q.bat_high, an_q.bat_low,
                         an_q.sw_ot, an_q.per_uv}; // [R13] [R19] [R20] [R21]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_q <= 4'h0;
        end else begin
            wake_q <= (wake_q & ~clr_of(`A_WAKE)) | {1'b0, wake_evt}; // [R5]
        end
    end

    // ==========================================================
    // interrupt pin
    logic [3:0] pend;

    assign pend[`IE_THERM]  = |therm_q; // [R8] [R9] [R14]
    assign pend[`IE_BAT]    = |supply_q[3:2]; // [R20] [R21]
    assign pend[`IE_WAKE]   = |wake_q; // [R4]
    assign pend[`IE_SUPPLY] = |supply_q[1:0];

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_n <= 1'b1;
        end else begin
            int_n <= ~|(pend & irq_en_q); // [R3] [R23]
        end
    end

    // ==========================================================
    // thermal latches
    logic main_off_q;
    logic per_off_q;
    logic sw_off_q;
    logic restart;

    assign restart = wr_evt && cmd.addr == `A_MODE
                  && cmd.data[`MODE_RESTART];

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_off_q <= 1'b0;
            per_off_q  <= 1'b0;
            sw_off_q   <= 1'b0;
        end else begin
            if (an_q.main_sd) begin
                main_off_q <= 1'b1; // [R9]
            end else if (!an_q.main_pw) begin
                main_off_q <= 1'b0; // [R10]
            end
            if (an_q.per_sd) begin
                per_off_q <= 1'b1; // [R15]
            end else if (restart) begin
                per_off_q <= 1'b0; // [R15]
            end
            sw_off_q <= an_q.sw_ot; // [R19]
        end
    end

    // ==========================================================
    // supply enables
    logic main_en_d;
    logic periph_en_d;
    logic switch_en_d;
    logic sw_mode;

    assign main_en_d = (mode == M_NREQ || mode == M_NORMAL
                     || mode == M_STANDBY) // [R6] [R11]
                    && !main_off_q && !an_q.main_sd // [R9]
                    && an_q.bat_ok; // [R11]

    assign periph_en_d = (mode == M_NORMAL) && main_en_d // [R12] [R16]
                      && !per_off_q && !an_q.per_sd; // [R15]

    always_comb begin
        case (mode)
            M_NORMAL:  sw_mode = sw_cfg_q[`CFG_NORMAL];
            M_STANDBY: sw_mode = sw_cfg_q[`CFG_STANDBY];
            M_SLEEP:   sw_mode = sw_cfg_q[`CFG_SLEEP] && an_q.cyc_on;
            default:   sw_mode = 1'b0; // [R18]
        endcase
    end

    // sleep is exempt from the main-off gate, else cyclic sense is dead
    assign switch_en_d = sw_mode // [R17]
                      && (main_en_d || mode == M_SLEEP) // [R18]
                      && !per_off_q // [R18]
                      && !sw_off_q && !an_q.sw_ot; // [R19]

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_en   <= 1'b0;
            periph_en <= 1'b0;
            switch_en <= 1'b0;
        end else begin
            main_en   <= main_en_d;
            periph_en <= periph_en_d;
            switch_en <= switch_en_d;
        end
    end

    // ==========================================================
    // read-back, captured when a frame lands
    logic [3:0] rdata;

    always_comb begin
        case (cmd.addr)
            `A_MODE:   rdata = {1'b0, mode};
            `A_IRQ_EN: rdata = irq_en_q;
            `A_SW_CFG: rdata = sw_cfg_q;
            `A_CAUSE:  rdata = cause_q;
            `A_THERM:  rdata = therm_q;
            `A_SUPPLY: rdata = supply_q;
            `A_WAKE:   rdata = wake_q;
            default:   rdata = {1'b0, an_q.level}; // [R5]
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reply_q <= 7'h00;
        end else if (rx_evt) begin
            reply_q <= {cmd.addr, rdata};
        end
    end

    // ==========================================================
    // checks
    sequence s_drive8;
        !rst_oe_n [*8];
    endsequence

    AST_RST_PULSE: assert property ( // [R1]
        @(posedge core_clk) disable iff (!reset_n)
        $fell(an_q.main_uv) |=> s_drive8)
        else $error("reset pulse too short after undervoltage");

    AST_UV_CAUSE: assert property ( // [R7]
        @(posedge core_clk) disable iff (!reset_n)
        an_q.main_uv |=> cause_q[`CAUSE_UV] && !rst_oe_n)
        else $error("undervoltage not flagged or reset not driven");

    AST_EXT_NREQ: assert property ( // [R2]
        @(posedge core_clk) disable iff (!reset_n)
        ext_rel |=> mode == M_NREQ)
        else $error("host reset release did not enter normal request");

    AST_INT_LOW: assert property ( // [R23]
        @(posedge core_clk) disable iff (!reset_n)
        |(pend & irq_en_q) |=> !int_n)
        else $error("enabled pending source left interrupt high");

    AST_INT_HIGH: assert property ( // [R3]
        @(posedge core_clk) disable iff (!reset_n)
        !(|(pend & irq_en_q)) |=> int_n)
        else $error("interrupt low with nothing enabled pending");

    AST_MAIN_SLEEP: assert property ( // [R11]
        @(posedge core_clk) disable iff (!reset_n)
        mode == M_SLEEP || mode == M_EMERG |=> !main_en)
        else $error("main regulator on in sleep or emergency");

    AST_MAIN_SHUT: assert property ( // [R9]
        @(posedge core_clk) disable iff (!reset_n)
        an_q.main_sd |=> !main_en && main_off_q)
        else $error("main regulator not shut off on overtemperature");

    AST_PER_NORMAL: assert property ( // [R12]
        @(posedge core_clk) disable iff (!reset_n)
        periph_en |-> $past(mode) == M_NORMAL)
        else $error("peripheral regulator on outside normal mode");

    AST_PER_MAIN: assert property ( // [R16]
        @(posedge core_clk) disable iff (!reset_n)
        periph_en |-> main_en)
        else $error("peripheral regulator on while main is off");

    AST_SW_NREQ: assert property ( // [R18]
        @(posedge core_clk) disable iff (!reset_n)
        mode == M_NREQ || per_off_q |=> !switch_en)
        else $error("battery switch on in normal request or shutdown");

    AST_BAT_LOW: assert property ( // [R20]
        @(posedge core_clk) disable iff (!reset_n)
        an_q.bat_low |=> supply_q[2] && pend[`IE_BAT])
        else $error("battery low not flagged");

endmodule : supply_mode_monitor_control

/* sim/spi_host_model.sv */
// host side serial master model with its own link clock
`timescale 1ns/100ps

module spi_host_model (
    // serial port toward the device
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    logic [7:0] rx;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
        rx   = 8'h00;
    end

    // ======================================================
    // one frame of n bits, msb first
    // sclk only runs while selected; mosi idles inverted
    task automatic xfer(input logic [7:0] tx, input int n,
                        output logic [7:0] got);
        int i;
        #3;
        cs_n = 1'b0;
        for (i = 7; i > 7 - n; i--) begin
            mosi = tx[i];
            #16 sclk = 1'b1;
            rx = {rx[6:0], miso};
            #16 sclk = 1'b0;
        end
        got = rx;
        #16 cs_n = 1'b1;
        mosi = ~mosi;
        // gap covers the reply update time
        #80;
    endtask : xfer
endmodule : spi_host_model

/* sim/test_supply_mode_monitor_control.sv */
// self-checking bench of the supply mode monitor and control block
`timescale 1ns/100ps

module test_supply_mode_monitor_control
    import supply_pkg::*;
;
    localparam int PULSE = 20;
    logic core_clk, reset_n, rst_in, host_rst, sclk, cs_n, mosi, miso;
    logic rst_out, rst_oe_n, int_n, main_en, periph_en, switch_en;
    analog_t    sense;
    mode_t      mode;
    int         mismatches, checked, seed, i, n;
    logic [7:0] got;
    logic [3:0] v;

    // pin has a pull-up; either party may pull it low
    assign rst_in = (rst_oe_n | rst_out) & ~host_rst;

    supply_mode_monitor_control #(.RST_PULSE_CYCLES(PULSE)) dut (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .sense    (sense),
        .rst_in   (rst_in),
        .sclk     (sclk),
        .cs_n     (cs_n),
        .mosi     (mosi),
        .miso     (miso),
        .rst_out  (rst_out),
        .rst_oe_n (rst_oe_n),
        .int_n    (int_n),
        .main_en  (main_en),
        .periph_en(periph_en),
        .switch_en(switch_en),
        .mode     (mode)
    );

    spi_host_model host (
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi),
        .miso(miso)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ======================================================
    // helpers
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check

    task automatic finish_test;
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask : cyc

    // supply status bit of source k: periph uv, battery low, battery high
    function automatic logic [3:0] supply_bit(input int k);
        return 4'h1 << ((k == 0) ? 0 : k + 1);
    endfunction : supply_bit

    task automatic wr(input logic [2:0] a, input logic [3:0] d);
        host.xfer({1'b1, a, d}, 8, got);
        cyc(2);
    endtask : wr

    // reply of a read arrives in the following frame
    task automatic rd(input logic [2:0] a);
        host.xfer({1'b0, a, 4'h0}, 8, got);
        host.xfer(8'h70, 8, got);
        check(got[7:4], {1'b0, a});
        v = got[3:0];
        cyc(1);
    endtask : rd

    // bounded wait for a pulse, then its low time in cycles
    task automatic pulse_len(output int k);
        k = 0;
        for (i = 0; i < 50 && rst_oe_n !== 1'b0; i++) begin
            cyc(1);
        end
        // no pulse ever started counts as a timeout too
        if (rst_oe_n !== 1'b0) begin
            k = 200;
        end
        while (rst_oe_n !== 1'b1 && k < 200) begin
            cyc(1);
            k++;
        end
        if (k >= 200) begin
            mismatches++;
            finish_test();
        end
    endtask : pulse_len

    // ======================================================
    // scenarios
    initial begin
        mismatches = 0;
        checked = 0;
        seed = 59;
        reset_n = 1'b0;
        host_rst = 1'b0;
        sense = '0;
        sense.bat_ok = 1'b1;
        // step past the clock's x-to-0 change at time zero
        #1;
        cyc(2);
        reset_n = 1'b1;
        pulse_len(n);
        check(n >= PULSE - 1 && n <= PULSE + 4, 1);
        check(mode, M_NREQ);
        check({main_en, periph_en, switch_en}, 3'b100);
        rd(3'h3);
        check(v[0], 1'b1);
        wr(3'h1, 4'hf);
        for (n = 0; n < 2; n++) begin
            wr(3'h0, n[3:0]);
            for (i = 0; i < 3; i++) begin
                v = $random(seed);
                wr(3'h2, v);
                check(switch_en, v[n]);
            end
            check({main_en, periph_en}, {1'b1, n == 0});
        end
        wr(3'h0, 4'h0);
        wr(3'h2, 4'h1);
        host.xfer(8'h82, 4, got);
        cyc(4);
        check(mode, M_NORMAL);
        sense.level = $random(seed);
        cyc(4);
        rd(3'h7);
        check(v[2:0], sense.level);
        sense.main_pw = 1'b1;
        cyc(6);
        check(int_n, 1'b0);
        sense.main_sd = 1'b1;
        cyc(6);
        check({main_en, periph_en, switch_en}, 3'b000);
        sense.main_sd = 1'b0;
        cyc(6);
        check(main_en, 1'b0);
        sense.main_pw = 1'b0;
        cyc(6);
        check({main_en, periph_en}, 2'b11);
        rd(3'h4);
        check(v[1:0], 2'b11);
        wr(3'h4, 4'hf);
        check(int_n, 1'b1);
        sense.per_pw = 1'b1;
        cyc(6);
        check(int_n, 1'b0);
        sense.per_sd = 1'b1;
        cyc(6);
        check({periph_en, switch_en}, 2'b00);
        sense.per_pw = 1'b0;
        sense.per_sd = 1'b0;
        wr(3'h4, 4'hf);
        check(periph_en, 1'b0);
        wr(3'h0, 4'h4);
        check({periph_en, switch_en, int_n}, 3'b111);
        sense.sw_ot = 1'b1;
        cyc(6);
        check({switch_en, int_n}, 2'b00);
        rd(3'h5);
        check(v[1], 1'b1);
        sense.sw_ot = 1'b0;
        cyc(6);
        check(switch_en, 1'b1);
        wr(3'h5, 4'hf);
        for (i = 0; i < 3; i++) begin
            {sense.per_uv, sense.bat_low, sense.bat_high} = 3'b100 >> i;
            cyc(6);
            check({int_n, main_en}, 2'b01);
            rd(3'h5);
            check(v, supply_bit(i));
            {sense.per_uv, sense.bat_low, sense.bat_high} = 3'b000;
            wr(3'h5, 4'hf);
            check(int_n, 1'b1);
        end
        wr(3'h1, 4'h0);
        sense.bat_high = 1'b1;
        cyc(6);
        check(int_n, 1'b1);
        sense.bat_high = 1'b0;
        wr(3'h5, 4'hf);
        wr(3'h1, 4'hf);
        host_rst = 1'b1;
        cyc(10);
        host_rst = 1'b0;
        cyc(10);
        check(mode, M_NREQ);
        rd(3'h3);
        check(v[1], 1'b1);
        wr(3'h3, 4'hf);
        wr(3'h0, 4'h0);
        sense.main_uv = 1'b1;
        cyc(6);
        check({rst_oe_n, mode}, {1'b0, M_NREQ});
        sense.main_uv = 1'b0;
        pulse_len(n);
        check(n >= PULSE - 1 && n <= PULSE + 4, 1);
        rd(3'h3);
        check(v[0], 1'b1);
        wr(3'h2, 4'h4);
        sense.cyc_on = 1'b1;
        wr(3'h0, 4'h2);
        cyc(4);
        check({mode, main_en, periph_en, switch_en},
              {M_SLEEP, 3'b001});
        sense.cyc_on = 1'b0;
        cyc(6);
        check(switch_en, 1'b0);
        sense.level = ~sense.level;
        pulse_len(n);
        check(n >= PULSE - 1 && n <= PULSE + 4, 1);
        cyc(4);
        check({mode, main_en, switch_en, int_n},
              {M_NREQ, 3'b100});
        wr(3'h6, 4'h7);
        check(int_n, 1'b1);
        wr(3'h0, 4'h3);
        cyc(4);
        check({mode, main_en}, {M_EMERG, 1'b0});
        wr(3'h0, 4'h0);
        sense.bat_ok = 1'b0;
        cyc(6);
        check(main_en, 1'b0);
        finish_test();
    end
endmodule : test_supply_mode_monitor_control
